// *** hw/sbt_pkg.sv ***
// Package with register map, field layout and reset values of the interval timer
package sbt_pkg;
  localparam int unsigned ADDR_W         = 3;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned COUNT_W        = 16;
  localparam int unsigned PRE_W          = 3;

  // Register offsets
  localparam logic [2:0]  ADDR_CONTROL   = 3'h0;
  localparam logic [2:0]  ADDR_COUNT_LO  = 3'h1;
  localparam logic [2:0]  ADDR_COUNT_HI  = 3'h2;
  localparam logic [2:0]  ADDR_STATUS    = 3'h3;
  localparam logic [2:0]  ADDR_CLEAR     = 3'h4;
  localparam logic [2:0]  ADDR_ENABLE    = 3'h5;
  localparam logic [2:0]  ADDR_IRQ_CTRL  = 3'h6;

  // Control register fields
  localparam int unsigned CTL_RUN_BIT    = 0;
  localparam int unsigned CTL_CSEL_BIT   = 1;
  localparam int unsigned CTL_DIV_LSB    = 4;
  localparam int unsigned CTL_DIV_MSB    = 5;

  // Status, clear and enable fields
  localparam int unsigned STS_ROLL_BIT   = 0;
  // Interrupt control fields
  localparam int unsigned IRQ_PERI_BIT   = 6;
  localparam int unsigned IRQ_GLOB_BIT   = 7;

  // Reset values, count maximum and unmapped read value
  localparam logic [1:0]  RST_DIV        = 2'h0;
  localparam logic [15:0] RST_COUNT      = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  localparam logic [7:0]  RD_UNMAPPED    = 8'h00;

  // System clock to instruction clock ratio
  localparam int unsigned INSTR_DIV      = 4;
  localparam logic [1:0]  INSTR_LAST     = 2'(INSTR_DIV - 1);
endpackage : sbt_pkg

// *** hw/sbt_tick_if.sv ***
// Interface between the timer core and its prescaler
interface sbt_tick_if;
  logic       src_tick;
  logic       clear;
  logic [1:0] ratio;
  logic       tick;

  modport core (output src_tick, output clear, output ratio, input tick);
  modport pre  (input src_tick, input clear, input ratio, output tick);
endinterface : sbt_tick_if

// *** hw/sbt_prescaler.sv ***
// Prescaler dividing the selected count clock by 1, 2, 4 or 8
module sbt_prescaler (
  input  wire logic   i_clk,
  input  wire logic   i_sys_rst,
  sbt_tick_if.pre     pre_if
);
  import sbt_pkg::*;

  logic [PRE_W-1:0] pre_cnt_q;
  logic [PRE_W-1:0] mask;

  always_comb begin
    mask = PRE_W'((4'h1 << pre_if.ratio) - 4'h1);
  end

  assign pre_if.tick = pre_if.src_tick && ((pre_cnt_q & mask) == mask);

  // Hidden counter, cleared by count writes
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || pre_if.clear) begin
      pre_cnt_q <= '0;
    end else if (pre_if.tick) begin
      pre_cnt_q <= '0;
    end else if (pre_if.src_tick) begin
      pre_cnt_q <= pre_cnt_q + PRE_W'(1);
    end
  end

  AST_PRE_CLEAR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pre_if.clear |=> pre_cnt_q == '0)
    else $error("prescaler not cleared by count write");

  AST_PRE_RATIO8: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pre_if.tick && pre_if.ratio == 2'h3 |-> pre_cnt_q == 3'h7)
    else $error("prescaler 1:8 ticked early");
endmodule : sbt_prescaler

// *** hw/sbt_timer.sv ***
// Sixteen-bit interval timer with prescaler, rollover flag and interrupt
// Operation
// - 16-bit counter, byte writes replace live count
// - Run bit enables; clearing stops, clears gate
// - Clock select: system clock or divided by four
// - Two-bit field selects 1:1 to 1:8 prescale
// - Hidden prescaler, cleared on count byte write
// - Wrap FFFF to 0000 sets rollover flag
// - Interrupt needs run, rollover, peripheral, global enables
// - No counting in Sleep, no wake-up
// - Control bits 7:6, 3:2 read zero
// - System clock, 1:1: four counts per instruction
module sbt_timer (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic [sbt_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [sbt_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  input  wire logic                        i_sleep,
  output logic      [sbt_pkg::DATA_W-1:0]  o_rdata,
  output logic                             o_irq
);
  import sbt_pkg::*;

  logic               run_q;
  logic               csel_q;
  logic [1:0]         div_q;
  logic               gate_q;
  logic [1:0]         instr_cnt_q;
  logic               instr_en;
  logic [COUNT_W-1:0] count_q;
  logic               roll_flag_q;
  logic               roll_ie_q;
  logic               peri_ie_q;
  logic               glob_ie_q;
  logic               wr_lo;
  logic               wr_hi;
  logic               wr_any_cnt;
  logic               wrap;
  logic               clr_flag;
  logic               irq_d;
  logic [DATA_W-1:0]  rdata_d;

  sbt_tick_if tick_if ();

  sbt_prescaler u_pre (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .pre_if    (tick_if.pre)
  );

  // Write decode
  assign wr_lo      = i_wr && (i_addr == ADDR_COUNT_LO);
  assign wr_hi      = i_wr && (i_addr == ADDR_COUNT_HI);
  assign wr_any_cnt = wr_lo || wr_hi;
  assign clr_flag   = i_wr && (i_addr == ADDR_CLEAR) && i_wdata[STS_ROLL_BIT];

  // Control register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      run_q  <= 1'b0;
      csel_q <= 1'b0;
      div_q  <= RST_DIV;
    end else if (i_wr && i_addr == ADDR_CONTROL) begin
      run_q  <= i_wdata[CTL_RUN_BIT];
      csel_q <= i_wdata[CTL_CSEL_BIT];
      div_q  <= i_wdata[CTL_DIV_MSB:CTL_DIV_LSB];
    end
  end

  // Gate flip-flop follows the run bit
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !run_q) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= 1'b1;
    end
  end

  // Instruction clock enable, system clock divided by four
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      instr_cnt_q <= '0;
    end else begin
      instr_cnt_q <= instr_cnt_q + 2'h1;
    end
  end
  assign instr_en = (instr_cnt_q == INSTR_LAST);

  // Prescaler source, halted when stopped or asleep
  assign tick_if.src_tick = gate_q && !i_sleep && (csel_q || instr_en);
  assign tick_if.clear    = wr_any_cnt;
  assign tick_if.ratio    = div_q;

  assign wrap = tick_if.tick && !wr_any_cnt && (count_q == COUNT_MAX);

  // Counter
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      count_q <= RST_COUNT;
    end else if (wr_lo) begin
      count_q[7:0] <= i_wdata;
    end else if (wr_hi) begin
      count_q[15:8] <= i_wdata;
    end else if (tick_if.tick) begin
      count_q <= count_q + COUNT_W'(1);
    end
  end

  // Rollover flag, set wins over clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      roll_flag_q <= 1'b0;
    end else if (wrap) begin
      roll_flag_q <= 1'b1;
    end else if (clr_flag) begin
      roll_flag_q <= 1'b0;
    end
  end

  // Interrupt enables
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      roll_ie_q <= 1'b0;
      peri_ie_q <= 1'b0;
      glob_ie_q <= 1'b0;
    end else begin
      if (i_wr && i_addr == ADDR_ENABLE) begin
        roll_ie_q <= i_wdata[STS_ROLL_BIT];
      end
      if (i_wr && i_addr == ADDR_IRQ_CTRL) begin
        peri_ie_q <= i_wdata[IRQ_PERI_BIT];
        glob_ie_q <= i_wdata[IRQ_GLOB_BIT];
      end
    end
  end

  // Interrupt output
  assign irq_d = roll_flag_q && run_q && roll_ie_q && peri_ie_q && glob_ie_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_d;
    end
  end

  // Read mux
  always_comb begin
    rdata_d = RD_UNMAPPED;
    unique case (i_addr)
      ADDR_CONTROL: begin
        rdata_d[CTL_RUN_BIT]             = run_q;
        rdata_d[CTL_CSEL_BIT]            = csel_q;
        rdata_d[CTL_DIV_MSB:CTL_DIV_LSB] = div_q;
      end
      ADDR_COUNT_LO: begin
        rdata_d = count_q[7:0];
      end
      ADDR_COUNT_HI: begin
        rdata_d = count_q[15:8];
      end
      ADDR_STATUS: begin
        rdata_d[STS_ROLL_BIT] = roll_flag_q;
      end
      ADDR_ENABLE: begin
        rdata_d[STS_ROLL_BIT] = roll_ie_q;
      end
      ADDR_IRQ_CTRL: begin
        rdata_d[IRQ_PERI_BIT] = peri_ie_q;
        rdata_d[IRQ_GLOB_BIT] = glob_ie_q;
      end
      default: begin
        rdata_d = RD_UNMAPPED;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= RD_UNMAPPED;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= RD_UNMAPPED;
    end
  end

  // Checks
  sequence s_fast_run;
    run_q && csel_q && div_q == 2'h0 && !i_sleep && !wr_any_cnt;
  endsequence

  sequence s_held_stop;
    (!gate_q || i_sleep) && !wr_any_cnt;
  endsequence

  AST_WRITE_LOW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_lo |=> count_q[7:0] == $past(i_wdata) && $stable(count_q[15:8]))
    else $error("low byte write not applied");

  AST_WRITE_HIGH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_hi |=> count_q[15:8] == $past(i_wdata) && $stable(count_q[7:0]))
    else $error("high byte write not applied");

  AST_STOP_HOLDS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!run_q |=> !gate_q) and (!run_q ##1 s_held_stop |=> $stable(count_q)))
    else $error("counter moved while stopped");

  AST_SLEEP_FROZEN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_sleep && !wr_any_cnt |=> $stable(count_q))
    else $error("counter moved during sleep");

  AST_INSTR_SRC: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    tick_if.tick && !csel_q |-> instr_cnt_q == INSTR_LAST)
    else $error("instruction clock tick off phase");

  AST_STEP_ONE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    tick_if.tick && !wr_any_cnt |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not step by one");

  AST_WRAP_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    tick_if.tick && !wr_any_cnt && count_q == COUNT_MAX |=> count_q == RST_COUNT && roll_flag_q)
    else $error("rollover did not wrap or flag");

  AST_FLAG_STICKY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    roll_flag_q && !clr_flag |=> roll_flag_q)
    else $error("rollover flag cleared by hardware");

  AST_IRQ_GATE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 o_irq == $past(roll_flag_q && run_q && roll_ie_q && peri_ie_q && glob_ie_q))
    else $error("interrupt output disagrees with enables");

  AST_RSVD_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_rd && i_addr == ADDR_CONTROL |=> o_rdata[7:6] == 2'h0 && o_rdata[3:2] == 2'h0)
    else $error("unused control bits read non-zero");

  AST_FOUR_PER_INSTR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_fast_run [*6] |-> count_q == $past(count_q, 4) + 16'h0004)
    else $error("system clock did not give four counts per instruction");

  AST_RESET_CTRL: assert property (@(posedge i_clk)
    $past(i_sys_rst) |-> !run_q && !csel_q && div_q == RST_DIV)
    else $error("control bits not zero after reset");
endmodule : sbt_timer

// *** verif/sbt_timer_tb.sv ***
// Self-checking testbench of the sixteen-bit interval timer
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module sbt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbt_pkg::*;

  logic              i_clk;
  logic              i_sys_rst;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic              i_wr;
  logic              i_rd;
  logic              i_sleep;
  logic [DATA_W-1:0] o_rdata;
  logic              o_irq;
  int                error_cnt;
  int                n_checks;

  sbt_timer DUT (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .i_wr      (i_wr),
    .i_rd      (i_rd),
    .i_sleep   (i_sleep),
    .o_rdata   (o_rdata),
    .o_irq     (o_irq)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  // Low-byte advance between two reads taken k cycles apart
  task automatic rate_chk(input int k, input logic [7:0] e);
    logic [7:0] d0;
    logic [7:0] d1;
    rd(ADDR_COUNT_LO, d0);
    repeat (k - 2) @(posedge i_clk);
    rd(ADDR_COUNT_LO, d1);
    `CHK(8'(d1 - d0), e)
  endtask

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    `CHK(o_irq, e)
  endtask

  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  initial begin
    int k;
    i_sys_rst = 1'b1;
    i_addr    = 3'h0;
    i_wdata   = 8'h00;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    i_sleep   = 1'b0;
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd_chk(ADDR_CONTROL, 8'h00);
    rd_chk(ADDR_COUNT_LO, 8'h00);
    rd_chk(ADDR_COUNT_HI, 8'h00);
    rd_chk(ADDR_STATUS, 8'h00);
    wr(ADDR_CONTROL, 8'hFF);
    rd_chk(ADDR_CONTROL, 8'h33);
    rd_chk(3'h7, 8'h00);
    rd_chk(ADDR_CLEAR, 8'h00);
    wr(ADDR_CONTROL, 8'h31);
    wr(ADDR_COUNT_HI, 8'h5A);
    rd_chk(ADDR_COUNT_HI, 8'h5A);
    wr(ADDR_COUNT_LO, 8'hC3);
    rd_chk(ADDR_COUNT_LO, 8'hC3);
    // Every clock source and divide ratio: eight ticks per window
    for (int c = 0; c < 2; c++) begin
      for (int dv = 0; dv < 4; dv++) begin
        k = 8 * (c == 1 ? 1 : INSTR_DIV) * (1 << dv);
        wr(ADDR_CONTROL, 8'((dv << 4) | (c << 1) | 1));
        repeat (16) @(posedge i_clk);
        rate_chk(k, 8'h08);
      end
    end
    wr(ADDR_CONTROL, 8'h03);
    rate_chk(4, 8'h04);
    @(posedge i_clk);
    i_sleep <= 1'b1;
    repeat (3) @(posedge i_clk);
    rate_chk(16, 8'h00);
    @(posedge i_clk);
    i_sleep <= 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    repeat (3) @(posedge i_clk);
    rate_chk(16, 8'h00);
    // Rollover with every enable set
    wr(ADDR_COUNT_HI, 8'h00);
    wr(ADDR_COUNT_LO, 8'h00);
    wr(ADDR_CLEAR, 8'h01);
    wr(ADDR_ENABLE, 8'h01);
    wr(ADDR_IRQ_CTRL, 8'hC0);
    irq_chk(1'b0);
    wr(ADDR_COUNT_HI, 8'hFF);
    wr(ADDR_COUNT_LO, 8'hF0);
    wr(ADDR_CONTROL, 8'h03);
    repeat (40) @(posedge i_clk);
    irq_chk(1'b1);
    wr(ADDR_IRQ_CTRL, 8'h40);
    irq_chk(1'b0);
    wr(ADDR_IRQ_CTRL, 8'hC0);
    irq_chk(1'b1);
    wr(ADDR_ENABLE, 8'h00);
    irq_chk(1'b0);
    wr(ADDR_ENABLE, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    irq_chk(1'b0);
    rd_chk(ADDR_COUNT_HI, 8'h00);
    rd_chk(ADDR_STATUS, 8'h01);
    repeat (50) @(posedge i_clk);
    rd_chk(ADDR_STATUS, 8'h01);
    wr(ADDR_CLEAR, 8'h01);
    rd_chk(ADDR_STATUS, 8'h00);
    // Reset again in mid-run
    wr(ADDR_CONTROL, 8'h33);
    repeat (3) @(posedge i_clk);
    // Count write restarts the 1:8 prescaler: first step eight cycles later
    wr(ADDR_COUNT_LO, 8'h00);
    repeat (6) @(posedge i_clk);
    rd_chk(ADDR_COUNT_LO, 8'h00);
    rd_chk(ADDR_COUNT_LO, 8'h01);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd_chk(ADDR_CONTROL, 8'h00);
    rd_chk(ADDR_ENABLE, 8'h00);
    summarize();
  end
endmodule // sbt_timer_tb
